// *** hw/device_end.sv ***
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - each transaction opens with one address byte
// - address then written bytes or returned bytes
// - input bit sampled on shift clock rise
// - output bit valid while shift clock high
// - host holds select low per transfer
// - address value fixes data byte count
// - all bytes shifted most significant first
// - host spaces repeated writes by aux periods
// - interrupt only for unmasked status change
// - host reads status after an interrupt
// - data lines never active together; host still drives serial input during read replies
// - command byte alone, value 01 resets
// - output undriven unless sending data
// - any clock level, gaps or back-to-back
module device_end (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  // serial link
  serial_port_if.device               link,
  // status sources and readback
  input  wire serial_port_pkg::word_t status_event,
  input  wire serial_port_pkg::word_t read_data,
  // register writes
  output logic                        wr_valid,
  output serial_port_pkg::addr_t      wr_addr,
  output serial_port_pkg::word_t      wr_data,
  // device controls
  output logic                        general_reset,
  output logic                        irq_pending
);
  // link domain
  logic                   link_clear;
  logic [4:0]             bit_cnt_reg;
  logic [4:0]             cnt_limit;
  logic [7:0]             addr_shift_reg;
  serial_port_pkg::addr_t addr_reg;
  logic                   addr_done_reg;
  serial_port_pkg::word_t data_shift_reg;
  serial_port_pkg::word_t rd_word_reg;
  logic [4:0]             sent_cnt_reg;
  logic                   reply_reg;
  logic                   reply_oe_reg;
  logic                   in_frame;
  logic                   last_bit;
  serial_port_pkg::addr_t addr_next;
  serial_port_pkg::addr_t hold_addr_reg;
  serial_port_pkg::word_t hold_data_reg;
  logic                   wr_tgl_reg;
  logic                   rst_tgl_reg;
  logic                   clr_tgl_reg;

  // system domain
  logic [3:0]             sys_sync;
  logic                   busy;
  logic                   wr_seen_reg;
  logic                   rst_seen_reg;
  logic                   clr_seen_reg;
  logic                   wr_edge;
  logic                   rst_edge;
  logic                   clr_edge;
  serial_port_pkg::word_t status_reg;
  serial_port_pkg::word_t status_next;
  serial_port_pkg::word_t mask_reg;
  serial_port_pkg::word_t status_shadow_reg;
  serial_port_pkg::word_t user_shadow_reg;

  assign link_clear = link.chip_select_low | reset;
  assign in_frame   = ~link.chip_select_low;
  assign cnt_limit  = addr_done_reg ? serial_port_pkg::frame_bits(addr_reg) : serial_port_pkg::ADDR_BITS;
  assign last_bit   = addr_done_reg && (bit_cnt_reg == cnt_limit - 5'h01);
  assign addr_next  = {addr_shift_reg[6:0], link.host_to_device_serial_in};

  // receive shifter, cleared whenever select is high
  always_ff @(posedge link.sclk or posedge link_clear) begin
    if (link_clear) begin
      bit_cnt_reg    <= 5'h00;
      addr_shift_reg <= 8'h00;
      addr_reg       <= 8'h00;
      addr_done_reg  <= 1'b0;
      data_shift_reg <= 16'h0000;
    end else if (bit_cnt_reg < cnt_limit) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
      if (!addr_done_reg) begin
        addr_shift_reg <= addr_next;
        if (bit_cnt_reg == serial_port_pkg::ADDR_BITS - 5'h01) begin
          addr_reg      <= addr_next;
          addr_done_reg <= 1'b1;
        end
      end else begin
        data_shift_reg <= {data_shift_reg[14:0], link.host_to_device_serial_in};
      end
    end
  end

  // reply word chosen once the address is known
  always_ff @(posedge link.sclk or posedge link_clear) begin
    if (link_clear) begin
      rd_word_reg <= 16'h0000;
    end else if (!addr_done_reg && bit_cnt_reg == serial_port_pkg::ADDR_BITS - 5'h01) begin
      if (addr_next == serial_port_pkg::ADDR_STATUS) begin
        rd_word_reg <= serial_port_pkg::align_word(status_shadow_reg,
                       serial_port_pkg::data_bytes(addr_next));
      end else begin
        rd_word_reg <= serial_port_pkg::align_word(user_shadow_reg,
                       serial_port_pkg::data_bytes(addr_next));
      end
    end
  end

  // reply driver, changes on the falling edge
  always_ff @(negedge link.sclk or posedge link_clear) begin
    if (link_clear) begin
      sent_cnt_reg <= 5'h00;
      reply_reg    <= 1'b0;
      reply_oe_reg <= 1'b0;
    end else if (addr_done_reg && serial_port_pkg::is_read(addr_reg)
                 && sent_cnt_reg < cnt_limit - serial_port_pkg::ADDR_BITS) begin
      reply_reg    <= rd_word_reg[4'(serial_port_pkg::WORD_MSB - sent_cnt_reg[3:0])];
      reply_oe_reg <= 1'b1;
      sent_cnt_reg <= sent_cnt_reg + 5'h01;
    end else begin
      reply_reg    <= 1'b0;
      reply_oe_reg <= 1'b0;
    end
  end

  assign link.reply_out = reply_reg;
  assign link.reply_oe  = reply_oe_reg;

  // completed transfers handed over by toggles
  always_ff @(posedge link.sclk or posedge reset) begin
    if (reset) begin
      hold_addr_reg <= 8'h00;
      hold_data_reg <= 16'h0000;
      wr_tgl_reg    <= 1'b0;
      rst_tgl_reg   <= 1'b0;
      clr_tgl_reg   <= 1'b0;
    end else if (in_frame) begin
      if (!addr_done_reg && bit_cnt_reg == serial_port_pkg::ADDR_BITS - 5'h01
          && addr_next == serial_port_pkg::ADDR_RESET) begin
        rst_tgl_reg <= ~rst_tgl_reg;
      end
      if (last_bit && !serial_port_pkg::is_read(addr_reg)) begin
        hold_addr_reg <= addr_reg;
        hold_data_reg <= (serial_port_pkg::data_bytes(addr_reg) == 2'h2)
                         ? {data_shift_reg[14:0], link.host_to_device_serial_in}
                         : {8'h00, data_shift_reg[6:0], link.host_to_device_serial_in};
        wr_tgl_reg    <= ~wr_tgl_reg;
      end
      if (last_bit && addr_reg == serial_port_pkg::ADDR_STATUS) begin
        clr_tgl_reg <= ~clr_tgl_reg;
      end
    end
  end

  // crossing into the system clock
  sync2 #(.W(4)) u_link_sync (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .async_in ({link.chip_select_low, wr_tgl_reg, rst_tgl_reg, clr_tgl_reg}),
    .sync_out (sys_sync)
  );

  assign busy     = ~sys_sync[3];
  assign wr_edge  = sys_sync[2] ^ wr_seen_reg;
  assign rst_edge = sys_sync[1] ^ rst_seen_reg;
  assign clr_edge = sys_sync[0] ^ clr_seen_reg;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_seen_reg  <= 1'b0;
      rst_seen_reg <= 1'b0;
      clr_seen_reg <= 1'b0;
    end else begin
      wr_seen_reg  <= sys_sync[2];
      rst_seen_reg <= sys_sync[1];
      clr_seen_reg <= sys_sync[0];
    end
  end

  // write strobe and command pulse
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_valid      <= 1'b0;
      wr_addr       <= 8'h00;
      wr_data       <= 16'h0000;
      general_reset <= 1'b0;
    end else begin
      wr_valid      <= wr_edge;
      general_reset <= rst_edge;
      if (wr_edge) begin
        wr_addr <= hold_addr_reg;
        wr_data <= hold_data_reg;
      end
    end
  end

  // interrupt mask
  always_ff @(posedge clk_sys) begin
    if (reset || rst_edge) begin
      mask_reg <= 16'h0000;
    end else if (wr_edge && hold_addr_reg == serial_port_pkg::ADDR_MASK) begin
      mask_reg <= hold_data_reg;
    end
  end

  // sticky status, new events win over the read clear
  always_comb begin
    status_next = status_reg;
    if (clr_edge) begin
      status_next = status_next & ~status_shadow_reg;
    end
    status_next = status_next | status_event;
  end

  always_ff @(posedge clk_sys) begin
    if (reset || rst_edge) begin
      status_reg <= 16'h0000;
    end else begin
      status_reg <= status_next;
    end
  end

  // snapshots frozen while select is low
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      status_shadow_reg <= 16'h0000;
      user_shadow_reg   <= 16'h0000;
    end else if (!busy && !clr_edge) begin
      status_shadow_reg <= status_reg;
      user_shadow_reg   <= read_data;
    end
  end

  // open-drain request, low while any unmasked bit is set
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_pending <= 1'b0;
    end else begin
      irq_pending <= |(status_reg & mask_reg);
    end
  end

  assign link.irq_out = 1'b0;
  assign link.irq_oe  = irq_pending;
endmodule : device_end
`default_nettype wire

// *** hw/host_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_end (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  // serial link
  serial_port_if.host                link,
  // request
  input  wire logic                  req_valid,
  output logic                       req_ready,
  input  wire serial_port_pkg::addr_t req_addr,
  input  wire serial_port_pkg::word_t req_wdata,
  // response
  output logic                       rsp_valid,
  output serial_port_pkg::word_t     rsp_rdata,
  // interrupt level
  output logic                       irq_request
);
  serial_port_pkg::host_state_t state_reg;
  logic [2:0]             phase_reg;
  logic [4:0]             bit_cnt_reg;
  logic [4:0]             total_reg;
  logic [23:0]            tx_reg;
  serial_port_pkg::word_t rx_reg;
  serial_port_pkg::addr_t addr_reg;
  logic                   sclk_reg;
  logic                   cs_low_reg;
  logic [7:0]             gap_reg;
  logic [1:0]             pin_sync;
  logic                   half_end;

  sync2 #(.W(2)) u_pin_sync (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .async_in ({link.reply_line, ~link.irq_request_low}),
    .sync_out (pin_sync)
  );

  assign half_end        = (phase_reg == serial_port_pkg::SCLK_HALF_LAST);
  assign req_ready       = (state_reg == serial_port_pkg::HOST_IDLE);
  // inverted ahead of the sync so reset reads as no request
  assign irq_request     = pin_sync[0];
  assign link.sclk       = sclk_reg;
  assign link.chip_select_low          = cs_low_reg;
  assign link.host_to_device_serial_in = tx_reg[23];

  // framing and shifting
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg   <= serial_port_pkg::HOST_IDLE;
      phase_reg   <= 3'h0;
      bit_cnt_reg <= 5'h00;
      total_reg   <= 5'h00;
      tx_reg      <= 24'h00_0000;
      rx_reg      <= 16'h0000;
      addr_reg    <= 8'h00;
      sclk_reg    <= 1'b0;
      cs_low_reg  <= 1'b1;
      gap_reg     <= 8'h00;
      rsp_valid   <= 1'b0;
      rsp_rdata   <= 16'h0000;
    end else begin
      rsp_valid <= 1'b0;
      case (state_reg)
        serial_port_pkg::HOST_IDLE: begin
          if (req_valid) begin
            addr_reg    <= req_addr;
            total_reg   <= serial_port_pkg::frame_bits(req_addr);
            tx_reg      <= {req_addr, serial_port_pkg::align_word(req_wdata,
                            serial_port_pkg::data_bytes(req_addr))};
            bit_cnt_reg <= 5'h00;
            phase_reg   <= 3'h0;
            rx_reg      <= 16'h0000;
            cs_low_reg  <= 1'b0;
            state_reg   <= serial_port_pkg::HOST_SHIFT;
          end
        end
        serial_port_pkg::HOST_SHIFT: begin
          phase_reg <= half_end ? 3'h0 : phase_reg + 3'h1;
          if (half_end && !sclk_reg) begin
            sclk_reg <= 1'b1;
          end else if (half_end) begin
            sclk_reg    <= 1'b0;
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            tx_reg      <= {tx_reg[22:0], 1'b0};
            if (serial_port_pkg::is_read(addr_reg) && bit_cnt_reg >= serial_port_pkg::ADDR_BITS) begin
              rx_reg <= {rx_reg[14:0], pin_sync[1]};
            end
            if (bit_cnt_reg == total_reg - 5'h01) begin
              cs_low_reg <= 1'b1;
              state_reg  <= serial_port_pkg::HOST_GAP;
              if (serial_port_pkg::is_read(addr_reg)) begin
                gap_reg <= serial_port_pkg::READ_GAP_CYCLES;
              end else if (addr_reg == serial_port_pkg::ADDR_MODE) begin
                gap_reg <= serial_port_pkg::MODE_GAP_CYCLES;
              end else begin
                gap_reg <= serial_port_pkg::OTHER_GAP_CYCLES;
              end
            end
          end
        end
        serial_port_pkg::HOST_GAP: begin
          if (gap_reg == 8'h00) begin
            rsp_valid <= 1'b1;
            rsp_rdata <= rx_reg;
            state_reg <= serial_port_pkg::HOST_IDLE;
          end else begin
            gap_reg <= gap_reg - 8'h01;
          end
        end
        default: state_reg <= serial_port_pkg::HOST_IDLE;
      endcase
    end
  end
endmodule : host_end
`default_nettype wire

// *** hw/sync2.sv ***
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset,
  // level in and out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : sync2
`default_nettype wire

// *** pkg/serial_port_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface serial_port_if;
  logic sclk;
  logic chip_select_low;
  logic host_to_device_serial_in;
  logic reply_out;
  logic reply_oe;
  logic irq_out;
  logic irq_oe;
  // resolved wires, pulled high when undriven
  logic reply_line;
  logic irq_request_low;

  assign reply_line      = reply_oe ? reply_out : 1'b1;
  assign irq_request_low = irq_oe ? irq_out : 1'b1;

  modport device (
    input  sclk,
    input  chip_select_low,
    input  host_to_device_serial_in,
    output reply_out,
    output reply_oe,
    output irq_out,
    output irq_oe
  );

  modport host (
    output sclk,
    output chip_select_low,
    output host_to_device_serial_in,
    input  reply_line,
    input  irq_request_low
  );
endinterface : serial_port_if
`default_nettype wire

// *** pkg/serial_port_pkg.sv ***
`default_nettype none
package serial_port_pkg;

  // timing
  localparam int CLK_PERIOD_NS     = 20;
  localparam int AUX_PERIOD_NS     = 1000;
  localparam int AUX_CYCLES        = (AUX_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MODE_GAP_PERIODS  = 3;
  localparam int OTHER_GAP_PERIODS = 1;
  localparam logic [7:0] MODE_GAP_CYCLES  = 8'(MODE_GAP_PERIODS * AUX_CYCLES);
  localparam logic [7:0] OTHER_GAP_CYCLES = 8'(OTHER_GAP_PERIODS * AUX_CYCLES);
  localparam logic [7:0] READ_GAP_CYCLES  = 8'h02;
  localparam logic [2:0] SCLK_HALF_LAST   = 3'h3;

  // address map
  localparam logic [7:0] ADDR_NOP    = 8'h00;
  localparam logic [7:0] ADDR_RESET  = 8'h01;
  localparam logic [7:0] ADDR_MODE   = 8'h41;
  localparam logic [7:0] ADDR_MASK   = 8'h4E;
  localparam logic [7:0] ADDR_STATUS = 8'hC6;
  localparam int READ_BIT = 7;
  localparam int LONG_BIT = 6;

  // framing
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam logic [4:0] ADDR_BITS = 5'h08;
  localparam logic [3:0] WORD_MSB  = 4'hF;

  typedef logic [7:0] addr_t;
  typedef logic [WORD_W-1:0] word_t;

  typedef enum logic [1:0] {
    HOST_IDLE  = 2'h0,
    HOST_SHIFT = 2'h1,
    HOST_GAP   = 2'h3
  } host_state_t;

  function automatic logic [1:0] data_bytes(input addr_t a);
    if (a == ADDR_NOP || a == ADDR_RESET) return 2'h0;
    return a[LONG_BIT] ? 2'h2 : 2'h1;
  endfunction : data_bytes

  function automatic logic is_read(input addr_t a);
    return a[READ_BIT];
  endfunction : is_read

  function automatic logic [4:0] frame_bits(input addr_t a);
    return ADDR_BITS + {data_bytes(a), 3'h0};
  endfunction : frame_bits

  function automatic word_t align_word(input word_t w, input logic [1:0] nbytes);
    return (nbytes == 2'h1) ? {w[BYTE_W-1:0], 8'h00} : w;
  endfunction : align_word

endpackage : serial_port_pkg
`default_nettype wire

// *** tb/host_serial_register_port_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_serial_register_port_tb;
  logic                   clk_sys      = 1'b0;
  logic                   reset        = 1'b0;
  logic                   req_valid    = 1'b0;
  serial_port_pkg::addr_t req_addr     = 8'h00;
  serial_port_pkg::word_t req_wdata    = 16'h0000;
  serial_port_pkg::word_t status_event = 16'h0000;
  serial_port_pkg::word_t read_data    = 16'h0000;
  logic                   req_ready;
  logic                   rsp_valid;
  serial_port_pkg::word_t rsp_rdata;
  logic                   irq_request;
  logic                   wr_valid;
  logic                   general_reset;
  logic                   irq_pending;
  serial_port_pkg::addr_t wr_addr;
  serial_port_pkg::word_t wr_data;
  serial_port_pkg::addr_t seen_addr;
  serial_port_pkg::word_t seen_data;
  int                     fail_count   = 0;
  int                     num_checks   = 0;
  int                     wr_count     = 0;
  int                     gr_count     = 0;

  always #10 clk_sys = ~clk_sys;

  serial_port_if link_if ();

  host_end host_end_i (
    .clk_sys(clk_sys), .reset(reset), .link(link_if), .req_valid(req_valid), .req_ready(req_ready),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .irq_request(irq_request)
  );

  device_end device_end_i (
    .clk_sys(clk_sys), .reset(reset), .link(link_if), .status_event(status_event),
    .read_data(read_data), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
    .general_reset(general_reset), .irq_pending(irq_pending)
  );

  serial_port_sva serial_port_sva_i (
    .clk_sys(clk_sys), .reset(reset), .sclk(link_if.sclk), .chip_select_low(link_if.chip_select_low),
    .host_to_device_serial_in(link_if.host_to_device_serial_in), .reply_out(link_if.reply_out),
    .reply_oe(link_if.reply_oe), .irq_out(link_if.irq_out), .irq_oe(link_if.irq_oe)
  );

  // device side write and reset pulses
  always @(posedge clk_sys) begin
    if (wr_valid === 1'b1) begin
      wr_count++;
      seen_addr = wr_addr;
      seen_data = wr_data;
    end
    if (general_reset === 1'b1) gr_count++;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  // one host request, waits for its response
  task automatic xfer(input logic [7:0] addr, input logic [15:0] wdata, output logic [15:0] rdata);
    int n;
    @(negedge clk_sys);
    req_valid = 1'b1;
    req_addr  = addr;
    req_wdata = wdata;
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    req_valid = 1'b0;
    check({15'h0000, req_ready}, 16'h0000);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 1000) begin
      @(negedge clk_sys);
      n++;
    end
    check({15'h0000, rsp_valid}, 16'h0001);
    rdata = rsp_rdata;
  endtask : xfer

  task automatic pulse_event(input logic [15:0] ev);
    @(negedge clk_sys);
    status_event = ev;
    @(negedge clk_sys);
    status_event = 16'h0000;
    repeat (10) @(negedge clk_sys);
  endtask : pulse_event

  task automatic t_writes;
    logic [7:0]  addrs [3] = '{8'h4E, 8'h05, 8'h41};
    logic [15:0] datas [3] = '{16'h1234, 16'hC3A5, 16'h8001};
    logic [15:0] r;
    int          wc;
    foreach (addrs[i]) begin
      wc = wr_count;
      xfer(addrs[i], datas[i], r);
      check(16'(wr_count - wc), 16'h0001);
      check({8'h00, seen_addr}, {8'h00, addrs[i]});
      check(seen_data, addrs[i][6] ? datas[i] : {8'h00, datas[i][7:0]});
      check(r, 16'h0000);
    end
  endtask : t_writes

  task automatic t_nop_reads;
    logic [15:0] r;
    int          wc;
    wc = wr_count;
    read_data = 16'hA55A;
    xfer(8'h00, 16'hFFFF, r);
    check(16'(wr_count + gr_count - wc), 16'(gr_count));
    xfer(8'hC0, 16'h0000, r);
    check(r, 16'hA55A);
    xfer(8'h85, 16'h0000, r);
    check(r, 16'h005A);
    check(16'(wr_count - wc), 16'h0000);
  endtask : t_nop_reads

  task automatic t_status_irq;
    logic [15:0] r;
    xfer(8'h4E, 16'h0000, r);
    pulse_event(16'h0020);
    check({15'h0000, irq_request}, 16'h0000);
    xfer(8'h4E, 16'h0004, r);
    check({15'h0000, irq_request}, 16'h0000);
    pulse_event(16'h0004);
    check({15'h0000, irq_request}, 16'h0001);
    xfer(8'hC6, 16'h0000, r);
    check(r, 16'h0024);
    repeat (10) @(negedge clk_sys);
    check({15'h0000, irq_request}, 16'h0000);
  endtask : t_status_irq

  task automatic t_gen_reset;
    logic [15:0] r;
    int          g;
    pulse_event(16'h0004);
    check({15'h0000, irq_pending}, 16'h0001);
    g = gr_count;
    xfer(8'h01, 16'h0000, r);
    check(16'(gr_count - g), 16'h0001);
    repeat (10) @(negedge clk_sys);
    check({15'h0000, irq_request}, 16'h0000);
    xfer(8'hC6, 16'h0000, r);
    check(r, 16'h0000);
  endtask : t_gen_reset

  initial begin
    #1 reset = 1'b1;
    repeat (12) @(negedge clk_sys);
    reset = 1'b0;
    t_writes();
    t_nop_reads();
    t_status_irq();
    t_gen_reset();
    give_verdict();
  end

  // hang guard
  initial begin
    repeat (30000) @(posedge clk_sys);
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule : host_serial_register_port_tb
`default_nettype wire

// *** tb/serial_port_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_port_sva (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  // link signals
  input  wire logic sclk,
  input  wire logic chip_select_low,
  input  wire logic host_to_device_serial_in,
  input  wire logic reply_out,
  input  wire logic reply_oe,
  input  wire logic irq_out,
  input  wire logic irq_oe
);
  logic       sclk_reg;
  logic [4:0] rise_reg;
  logic [7:0] addr_reg;
  logic [4:0] exp_bits;
  logic [7:0] high_cnt_reg;
  logic [7:0] need_gap_reg;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // previous shift clock level
  always_ff @(posedge clk_sys) begin
    sclk_reg <= reset ? 1'b0 : sclk;
  end

  // rising edges seen in the current frame
  always_ff @(posedge clk_sys) begin
    if (reset || chip_select_low) begin
      rise_reg <= 5'h00;
    end else if (sclk && !sclk_reg) begin
      rise_reg <= rise_reg + 5'h01;
    end
  end

  // address byte of the current frame
  always_ff @(posedge clk_sys) begin
    if (reset || chip_select_low) begin
      addr_reg <= 8'h00;
    end else if (sclk && !sclk_reg && rise_reg < 5'h08) begin
      addr_reg <= {addr_reg[6:0], host_to_device_serial_in};
    end
  end

  // frame length implied by the address
  assign exp_bits = (addr_reg[7:1] == 7'h00) ? 5'h08 : (addr_reg[6] ? 5'h18 : 5'h10);

  // cycles with select high since the last frame
  always_ff @(posedge clk_sys) begin
    if (reset || !chip_select_low) begin
      high_cnt_reg <= 8'h00;
    end else if (high_cnt_reg != 8'hFF) begin
      high_cnt_reg <= high_cnt_reg + 8'h01;
    end
  end

  // spacing owed by the last frame
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      need_gap_reg <= 8'h00;
    end else if (!chip_select_low) begin
      if (addr_reg[7] || exp_bits == 5'h08) begin
        need_gap_reg <= 8'h00;
      end else if (addr_reg == serial_port_pkg::ADDR_MODE) begin
        need_gap_reg <= serial_port_pkg::MODE_GAP_CYCLES;
      end else begin
        need_gap_reg <= serial_port_pkg::OTHER_GAP_CYCLES;
      end
    end
  end

  a_reply_in_frame : assert property (reply_oe |-> !chip_select_low)
    else $error("reply driven outside a frame");
  a_irq_open_drain : assert property (irq_oe |-> irq_out == 1'b0)
    else $error("request line driven high");
  a_sclk_in_frame : assert property ($rose(sclk) |-> !chip_select_low)
    else $error("shift clock rose without select");
  a_sclk_high_span : assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("shift clock high span wrong");
  a_sdi_stable_high : assert property (sclk && $past(sclk) |-> $stable(host_to_device_serial_in))
    else $error("host data moved while clock high");
  a_reply_stable_high : assert property (sclk && $past(sclk) && reply_oe |-> $stable(reply_out))
    else $error("reply moved while clock high");
  a_reply_after_addr : assert property ($rose(reply_oe) |-> rise_reg == 5'h08)
    else $error("reply began off the address boundary");
  a_reply_on_read : assert property ($rose(reply_oe) |-> addr_reg[7])
    else $error("reply driven for a write address");
  a_reply_span : assert property ($fell(reply_oe) |-> rise_reg == exp_bits)
    else $error("reply length does not match address");
  a_frame_length : assert property ($rose(chip_select_low) |-> rise_reg == exp_bits)
    else $error("frame length does not match address");
  a_write_spacing : assert property ($fell(chip_select_low) |-> high_cnt_reg >= need_gap_reg)
    else $error("frames spaced too closely after a write");
endmodule : serial_port_sva
`default_nettype wire
